// file: ddrpi_command_pins.sv
`timescale 1ns/1ps
module ddrpi_command_pins
  import ddrpi_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              reset_n,
  input  wire logic              req_valid,
  input  wire ddrpi_req_s        req,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_data,
  output logic                   rsp_timeout,
  input  wire logic              link_clk,
  output logic [1:0]             mem_clock_pair,
  output logic                   mem_clock_enable,
  output logic                   mem_chip_select_n,
  output logic                   mem_row_strobe_n,
  output logic                   mem_col_strobe_n,
  output logic                   mem_write_enable_n,
  output logic [BANK_W-1:0]      mem_bank_select,
  output logic [ADDR_W-1:0]      mem_address_out,
  output logic [LANES-1:0]       mem_byte_mask_n,
  output logic [ODT_W-1:0]       mem_termination_out,
  input  wire logic [DATA_W-1:0] mem_data_bus_in,
  output logic [DATA_W-1:0]      mem_data_bus_out,
  output logic                   mem_data_bus_oe_n,
  output logic [LANES-1:0]       mem_data_strobe_pair_out,
  output logic [LANES-1:0]       mem_data_strobe_pair_out_n,
  output logic                   mem_data_strobe_pair_oe_n,
  input  wire logic [LANES-1:0]  read_strobe_gate
);

  // ****************************************************************
  // Command encoding.
  // ****************************************************************
  function automatic ddrpi_cmd_s cmd_of(input ddrpi_op_e op, input ddrpi_req_s r);
    ddrpi_cmd_s c;
    c = '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, bank: '0, addr: '0};
    case (op)
      OP_ACTIVATE:
      begin
        c.ras_n = 1'b0;
        c.bank  = r.bank;
        c.addr  = r.addr;
      end
      OP_PRECHARGE_ALL:
      begin
        c.ras_n = 1'b0;
        c.we_n  = 1'b0;
        c.addr  = ADDR_ALL_BANKS;
      end
      OP_PRECHARGE_ONE:
      begin
        c.ras_n = 1'b0;
        c.we_n  = 1'b0;
        c.bank  = r.bank;
      end
      OP_MODE_SET, OP_EXT_MODE_SET:
      begin
        c.ras_n = 1'b0;
        c.cas_n = 1'b0;
        c.we_n  = 1'b0;
        c.bank  = {1'b0, r.bank[1:0]};
        c.addr  = {1'b0, r.addr[MODE_ADDR_MSB:0]};
      end
      OP_READ, OP_READ_AP:
      begin
        c.cas_n = 1'b0;
        c.bank  = r.bank;
        c.addr  = r.addr;
        c.addr[A10_BIT] = (op == OP_READ_AP);
      end
      OP_WRITE, OP_WRITE_AP:
      begin
        c.cas_n = 1'b0;
        c.we_n  = 1'b0;
        c.bank  = r.bank;
        c.addr  = r.addr;
        c.addr[A10_BIT] = (op == OP_WRITE_AP);
      end
      OP_AUTOREFRESH, OP_SELF_REFRESH_ENTRY:
      begin
        c.ras_n = 1'b0;
        c.cas_n = 1'b0;
      end
      default:
      begin
        c.ras_n = 1'b1;
      end
    endcase
    return c;
  endfunction : cmd_of

  // ****************************************************************
  // System clock side of the request handshake.
  // ****************************************************************
  ddrpi_req_s        held;
  logic              busy;
  logic              req_tgl;
  logic              ack_tgl;
  logic              ack_sync;
  logic              ack_seen;
  logic [DATA_W-1:0] link_rdata;
  logic              link_tmo;

  assign req_ready = !busy;

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      busy    <= 1'b0;
      req_tgl <= 1'b0;
      held    <= '0;
    end
    else if (req_valid && !busy)
    begin
      held    <= req;
      req_tgl <= ~req_tgl;
      busy    <= 1'b1;
    end
    else if (ack_sync != ack_seen)
    begin
      busy <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      ack_seen    <= 1'b0;
      rsp_valid   <= 1'b0;
      rsp_data    <= '0;
      rsp_timeout <= 1'b0;
    end
    else
    begin
      rsp_valid <= 1'b0;
      if (ack_sync != ack_seen)
      begin
        ack_seen    <= ack_sync;
        rsp_valid   <= 1'b1;
        rsp_data    <= link_rdata;
        rsp_timeout <= link_tmo;
      end
    end
  end

  ddrpi_sync #(.W(1)) u_ack_sync (
    .clk   (sys_clk),
    .rst_n (reset_n),
    .d     (ack_tgl),
    .q     (ack_sync)
  );

  // ****************************************************************
  // Link clock side crossings.
  // ****************************************************************
  logic              link_rst_n;
  logic              req_sync;
  logic [LANES-1:0]  gate_sync;
  logic [DATA_W-1:0] data_sync;

  ddrpi_sync #(.W(1)) u_rst_sync (
    .clk   (link_clk),
    .rst_n (1'b1),
    .d     (reset_n),
    .q     (link_rst_n)
  );

  ddrpi_sync #(.W(1)) u_req_sync (
    .clk   (link_clk),
    .rst_n (link_rst_n),
    .d     (req_tgl),
    .q     (req_sync)
  );

  ddrpi_sync #(.W(LANES)) u_gate_sync (
    .clk   (link_clk),
    .rst_n (link_rst_n),
    .d     (read_strobe_gate),
    .q     (gate_sync)
  );

  ddrpi_sync #(.W(DATA_W)) u_data_sync (
    .clk   (link_clk),
    .rst_n (link_rst_n),
    .d     (mem_data_bus_in),
    .q     (data_sync)
  );

  // ****************************************************************
  // Link sequencer.
  // ****************************************************************
  typedef enum logic [2:0] {LK_IDLE, LK_REFRESH, LK_WRITE, LK_READ, LK_DONE} ddrpi_link_e;

  ddrpi_link_e state;
  logic        req_seen;
  logic        new_req;
  logic [2:0]  beat;
  logic [4:0]  wait_cnt;
  ddrpi_op_e   issued_op;
  ddrpi_op_e   next_op;
  ddrpi_cmd_s  next_cmd;

  assign new_req = (state == LK_IDLE) && (req_sync != req_seen);

  always_ff @(posedge link_clk)
  begin
    if (!link_rst_n)
    begin
      state    <= LK_IDLE;
      req_seen <= 1'b0;
    end
    else
    begin
      case (state)
        LK_IDLE:
        begin
          if (new_req)
          begin
            req_seen <= req_sync;
            if (held.op == OP_AUTOREFRESH)
              state <= LK_REFRESH;
            else if (held.op == OP_WRITE || held.op == OP_WRITE_AP)
              state <= LK_WRITE;
            else if (held.op == OP_READ || held.op == OP_READ_AP)
              state <= LK_READ;
            else
              state <= LK_DONE;
          end
        end
        LK_REFRESH: state <= LK_DONE;
        LK_WRITE:
        begin
          if (beat == WRITE_LAST_BEAT)
            state <= LK_DONE;
        end
        LK_READ:
        begin
          if ((|gate_sync) || wait_cnt == READ_TIMEOUT)
            state <= LK_DONE;
        end
        default: state <= LK_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Command pins.
  // ****************************************************************
  always_comb
  begin
    next_op = OP_NOP;
    if (new_req)
      next_op = (held.op == OP_AUTOREFRESH) ? OP_PRECHARGE_ALL : held.op;
    else if (state == LK_REFRESH)
      next_op = OP_AUTOREFRESH;
    next_cmd = cmd_of(next_op, held);
  end

  always_ff @(posedge link_clk)
  begin
    if (!link_rst_n)
    begin
      issued_op          <= OP_NOP;
      mem_row_strobe_n   <= 1'b1;
      mem_col_strobe_n   <= 1'b1;
      mem_write_enable_n <= 1'b1;
      mem_bank_select    <= '0;
      mem_address_out    <= '0;
      mem_clock_enable   <= 1'b1;
    end
    else
    begin
      issued_op          <= next_op;
      mem_row_strobe_n   <= next_cmd.ras_n;
      mem_col_strobe_n   <= next_cmd.cas_n;
      mem_write_enable_n <= next_cmd.we_n;
      mem_bank_select    <= next_cmd.bank;
      mem_address_out    <= next_cmd.addr;
      if (next_op == OP_SELF_REFRESH_ENTRY || next_op == OP_POWER_DOWN_ENTRY)
        mem_clock_enable <= 1'b0;
      else if (next_op == OP_SELF_REFRESH_EXIT || next_op == OP_POWER_DOWN_EXIT)
        mem_clock_enable <= 1'b1;
    end
  end

  assign mem_chip_select_n   = 1'b0;
  assign mem_termination_out = ODT_OFF;
  assign mem_clock_pair      = {~link_clk, link_clk};

  // ****************************************************************
  // Write data and strobes.
  // ****************************************************************
  always_ff @(posedge link_clk)
  begin
    if (!link_rst_n)
    begin
      beat                       <= '0;
      mem_data_bus_out           <= '0;
      mem_data_bus_oe_n          <= 1'b1;
      mem_data_strobe_pair_out   <= '0;
      mem_data_strobe_pair_out_n <= MASK_NONE;
      mem_data_strobe_pair_oe_n  <= 1'b1;
      mem_byte_mask_n            <= MASK_NONE;
    end
    else if (state == LK_WRITE)
    begin
      beat                       <= beat + 3'h1;
      mem_data_bus_out           <= held.wdata;
      mem_data_bus_oe_n          <= 1'b0;
      mem_data_strobe_pair_out   <= {LANES{beat[0]}};
      mem_data_strobe_pair_out_n <= {LANES{~beat[0]}};
      mem_data_strobe_pair_oe_n  <= 1'b0;
      mem_byte_mask_n            <= (beat == 3'h0) ? held.byte_mask_n : MASK_ALL;
    end
    else
    begin
      beat                       <= '0;
      mem_data_bus_oe_n          <= 1'b1;
      mem_data_strobe_pair_out   <= '0;
      mem_data_strobe_pair_out_n <= MASK_NONE;
      mem_data_strobe_pair_oe_n  <= 1'b1;
      mem_byte_mask_n            <= MASK_NONE;
    end
  end

  // ****************************************************************
  // Read capture and completion.
  // ****************************************************************
  always_ff @(posedge link_clk)
  begin
    if (!link_rst_n)
    begin
      wait_cnt   <= '0;
      link_rdata <= '0;
      link_tmo   <= 1'b0;
      ack_tgl    <= 1'b0;
    end
    else
    begin
      if (new_req)
      begin
        wait_cnt   <= '0;
        link_rdata <= '0;
        link_tmo   <= 1'b0;
      end
      else if (state == LK_READ)
      begin
        wait_cnt <= wait_cnt + 5'h1;
        if (|gate_sync)
          link_rdata <= data_sync;
        else if (wait_cnt == READ_TIMEOUT)
          link_tmo <= 1'b1;
      end
      if (state == LK_DONE)
        ack_tgl <= ~ack_tgl;
    end
  end

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  cs_held_low_a : assert property (
    @(posedge link_clk) disable iff (!link_rst_n) mem_chip_select_n == 1'b0)
    else $error("Chip select left its low level.");

  pre_before_ref_a : assert property (
    @(posedge link_clk) disable iff (!link_rst_n)
    issued_op == OP_AUTOREFRESH |-> $past(issued_op) == OP_PRECHARGE_ALL)
    else $error("Autorefresh not preceded by precharge-all.");

  pre_all_pins_a : assert property (
    @(posedge link_clk) disable iff (!link_rst_n)
    issued_op == OP_PRECHARGE_ALL |-> mem_address_out[A10_BIT] && !mem_row_strobe_n
      && mem_col_strobe_n && !mem_write_enable_n)
    else $error("Precharge-all pins wrong.");

  mode_fields_a : assert property (
    @(posedge link_clk) disable iff (!link_rst_n)
    (issued_op == OP_MODE_SET || issued_op == OP_EXT_MODE_SET) |-> !mem_row_strobe_n
      && !mem_col_strobe_n && !mem_write_enable_n && mem_bank_select == {1'b0, held.bank[1:0]}
      && mem_address_out == {1'b0, held.addr[MODE_ADDR_MSB:0]})
    else $error("Mode set fields wrong.");

  read_pins_a : assert property (
    @(posedge link_clk) disable iff (!link_rst_n)
    (issued_op == OP_READ || issued_op == OP_READ_AP) |-> mem_row_strobe_n
      && !mem_col_strobe_n && mem_write_enable_n
      && mem_address_out[A10_BIT] == (issued_op == OP_READ_AP))
    else $error("Read command pins wrong.");

  activate_pins_a : assert property (
    @(posedge link_clk) disable iff (!link_rst_n)
    issued_op == OP_ACTIVATE |-> !mem_row_strobe_n && mem_col_strobe_n
      && mem_write_enable_n && mem_address_out == held.addr && mem_bank_select == held.bank)
    else $error("Activate pins wrong.");

  write_drive_a : assert property (
    @(posedge link_clk) disable iff (!link_rst_n)
    (issued_op == OP_WRITE || issued_op == OP_WRITE_AP) |-> ##1
      (!mem_data_bus_oe_n && !mem_data_strobe_pair_oe_n)[*4] ##1 mem_data_bus_oe_n)
    else $error("Write drive window wrong.");

  write_mask_a : assert property (
    @(posedge link_clk) disable iff (!link_rst_n)
    (issued_op == OP_WRITE || issued_op == OP_WRITE_AP) |-> ##1
      mem_byte_mask_n == held.byte_mask_n ##1 mem_byte_mask_n == MASK_ALL)
    else $error("Write byte mask wrong.");

  read_release_a : assert property (
    @(posedge link_clk) disable iff (!link_rst_n)
    state == LK_READ |-> mem_data_bus_oe_n && mem_data_strobe_pair_oe_n)
    else $error("Bus driven during read.");

  read_bound_a : assert property (
    @(posedge link_clk) disable iff (!link_rst_n)
    (issued_op == OP_READ || issued_op == OP_READ_AP) |-> ##[1:20] state == LK_DONE)
    else $error("Read not finished in time.");

  cke_low_a : assert property (
    @(posedge link_clk) disable iff (!link_rst_n)
    issued_op == OP_SELF_REFRESH_ENTRY |-> !mem_clock_enable && !mem_row_strobe_n
      && !mem_col_strobe_n && mem_write_enable_n)
    else $error("Self-refresh entry pins wrong.");

endmodule : ddrpi_command_pins

// file: ddrpi_command_pins_tb.sv
`timescale 1ns/1ps
// ****************************************************************
// Self-checking bench for the memory command pin block.
// ****************************************************************
`define CHK(nm, e, g) \
  begin \
    checked++; \
    if ((g) !== (e)) \
    begin \
      n_fail++; \
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g); \
    end \
  end

module ddrpi_command_pins_tb;
  import ddrpi_pkg::*;
  localparam logic [DATA_W-1:0] RD_WORD = 32'h5a3c_96e1;

  logic sys_clk, link_clk, reset_n, req_valid, req_ready, rsp_valid, rsp_timeout;
  logic mute, slow, cke, cs_n, ras_n, cas_n, we_n, dq_oe_n, dqs_oe_n;
  ddrpi_req_s        req;
  ddrpi_cmd_s        last_cmd, prev_cmd;
  logic [DATA_W-1:0] rsp_data, dq_in, dq_out, wr_data;
  logic [LANES-1:0]  mask_n, dqs, dqs_n, gate, wr_mask;
  logic [7:0]        wr_strobe;
  logic [1:0]        clk_pair;
  logic [ODT_W-1:0]  odt;
  logic [BANK_W-1:0] bank;
  logic [ADDR_W-1:0] addr;
  int                cmd_cnt, n_fail, checked, c0;

  ddrpi_command_pins u_ddrpi_command_pins (
    .sys_clk(sys_clk), .reset_n(reset_n), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_timeout(rsp_timeout), .link_clk(link_clk), .mem_clock_pair(clk_pair),
    .mem_clock_enable(cke), .mem_chip_select_n(cs_n), .mem_row_strobe_n(ras_n),
    .mem_col_strobe_n(cas_n), .mem_write_enable_n(we_n), .mem_bank_select(bank),
    .mem_address_out(addr), .mem_byte_mask_n(mask_n), .mem_termination_out(odt),
    .mem_data_bus_in(dq_in), .mem_data_bus_out(dq_out), .mem_data_bus_oe_n(dq_oe_n),
    .mem_data_strobe_pair_out(dqs), .mem_data_strobe_pair_out_n(dqs_n),
    .mem_data_strobe_pair_oe_n(dqs_oe_n), .read_strobe_gate(gate));

  ddrpi_mem_model #(.RD_WORD(RD_WORD)) u_ddrpi_mem_model (
    .link_clk(link_clk), .mute(mute), .slow(slow), .mem_row_strobe_n(ras_n),
    .mem_col_strobe_n(cas_n), .mem_write_enable_n(we_n), .mem_bank_select(bank),
    .mem_address_out(addr), .mem_byte_mask_n(mask_n), .mem_data_bus_out(dq_out),
    .mem_data_bus_oe_n(dq_oe_n), .mem_data_strobe_pair_out(dqs),
    .mem_data_strobe_pair_out_n(dqs_n), .mem_data_bus_in(dq_in),
    .read_strobe_gate(gate), .last_cmd(last_cmd), .prev_cmd(prev_cmd),
    .cmd_cnt(cmd_cnt), .wr_data(wr_data), .wr_mask(wr_mask), .wr_strobe(wr_strobe));

  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  initial
  begin
    link_clk = 1'b0;
    #3.7;
    forever #6 link_clk = ~link_clk;
  end

  task automatic test_done();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done

  task automatic do_op(input ddrpi_op_e op, input logic [BANK_W-1:0] b,
                       input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                       input logic [LANES-1:0] m);
    int n;
    @(posedge sys_clk);
    #2;
    req = '{op, b, a, d, m};
    req_valid = 1'b1;
    n = 0;
    while (req_ready !== 1'b1 && n < 50)
    begin
      @(posedge sys_clk);
      #2;
      n++;
    end
    @(posedge sys_clk);
    #2;
    req_valid = 1'b0;
    `CHK("ready low", 1'b0, req_ready)
    n = 0;
    while (rsp_valid !== 1'b1 && n < 400)
    begin
      @(posedge sys_clk);
      #2;
      n++;
    end
    `CHK("rsp_valid", 1'b1, rsp_valid)
    `CHK("ready back", 1'b1, req_ready)
  endtask : do_op

  task automatic chk_cmd(input string nm, input logic [2:0] rcw, input logic [BANK_W-1:0] b,
                         input logic a10);
    `CHK(nm, rcw, {last_cmd.ras_n, last_cmd.cas_n, last_cmd.we_n})
    `CHK(nm, b, last_cmd.bank)
    `CHK(nm, a10, last_cmd.addr[A10_BIT])
  endtask : chk_cmd

  task automatic t_idle();
    `CHK("idle strobes", 3'b111, {ras_n, cas_n, we_n})
    `CHK("chip select", 1'b0, cs_n)
    `CHK("termination", ODT_OFF, odt)
    `CHK("idle mask", MASK_NONE, mask_n)
    `CHK("idle bus", 2'b11, {dq_oe_n, dqs_oe_n})
    `CHK("idle cke", 1'b1, cke)
    @(posedge link_clk);
    #1;
    `CHK("clock pair", 2'b01, clk_pair)
  endtask : t_idle

  task automatic t_row_ops();
    do_op(OP_ACTIVATE, 3'h5, 14'h2abc, 32'h0, MASK_NONE);
    chk_cmd("activate", 3'b011, 3'h5, 1'b0);
    `CHK("activate row", 14'h2abc, last_cmd.addr)
    do_op(OP_PRECHARGE_ONE, 3'h6, 14'h0400, 32'h0, MASK_NONE);
    chk_cmd("precharge one", 3'b010, 3'h6, 1'b0);
    do_op(OP_PRECHARGE_ALL, 3'h0, 14'h0000, 32'h0, MASK_NONE);
    chk_cmd("precharge all", 3'b010, 3'h0, 1'b1);
  endtask : t_row_ops

  task automatic t_mode();
    do_op(OP_MODE_SET, 3'h5, 14'h3555, 32'h0, MASK_NONE);
    chk_cmd("mode set", 3'b000, 3'h1, 1'b1);
    `CHK("mode value", 14'h1555, last_cmd.addr)
    do_op(OP_EXT_MODE_SET, 3'h2, 14'h0a5a, 32'h0, MASK_NONE);
    chk_cmd("ext mode set", 3'b000, 3'h2, 1'b0);
    `CHK("ext mode value", 14'h0a5a, last_cmd.addr)
  endtask : t_mode

  task automatic t_read();
    for (int i = 0; i < 2; i++)
    begin
      slow = i[0];
      do_op(i[0] ? OP_READ_AP : OP_READ, 3'h2, 14'h0123, 32'h0, MASK_NONE);
      chk_cmd("read cmd", 3'b101, 3'h2, i[0]);
      `CHK("read column", 10'h123, last_cmd.addr[9:0])
      `CHK("read data", RD_WORD, rsp_data)
      `CHK("read timeout", 1'b0, rsp_timeout)
    end
    mute = 1'b1;
    do_op(OP_READ, 3'h1, 14'h0010, 32'h0, MASK_NONE);
    `CHK("no gate timeout", 1'b1, rsp_timeout)
    `CHK("no gate data", 32'h0, rsp_data)
    mute = 1'b0;
  endtask : t_read

  task automatic t_write();
    for (int i = 0; i < 2; i++)
    begin
      do_op(i[0] ? OP_WRITE_AP : OP_WRITE, 3'h4, 14'h0077, 32'hcafe_f00d ^ i, {3'b101, i[0]});
      chk_cmd("write cmd", 3'b100, 3'h4, i[0]);
      `CHK("write data", 32'hcafe_f00d ^ i, wr_data)
      `CHK("write mask", {3'b101, i[0]}, wr_mask)
      `CHK("write strobe", 8'h0f, wr_strobe)
      `CHK("bus released", 2'b11, {dq_oe_n, dqs_oe_n})
    end
  endtask : t_write

  task automatic t_refresh_power();
    c0 = cmd_cnt;
    do_op(OP_AUTOREFRESH, 3'h0, 14'h0000, 32'h0, MASK_NONE);
    `CHK("refresh count", 2, cmd_cnt - c0)
    `CHK("refresh", 3'b001, {last_cmd.ras_n, last_cmd.cas_n, last_cmd.we_n})
    `CHK("before refresh", 4'h5,
         {prev_cmd.ras_n, prev_cmd.cas_n, prev_cmd.we_n, prev_cmd.addr[A10_BIT]})
    do_op(OP_SELF_REFRESH_ENTRY, 3'h0, 14'h0000, 32'h0, MASK_NONE);
    `CHK("self refresh", 4'h2, {last_cmd.ras_n, last_cmd.cas_n, last_cmd.we_n, cke})
    c0 = cmd_cnt;
    do_op(OP_SELF_REFRESH_EXIT, 3'h0, 14'h0000, 32'h0, MASK_NONE);
    `CHK("self refresh exit", 1'b1, cke)
    do_op(OP_POWER_DOWN_ENTRY, 3'h0, 14'h0000, 32'h0, MASK_NONE);
    `CHK("power down", 1'b0, cke)
    do_op(OP_POWER_DOWN_EXIT, 3'h0, 14'h0000, 32'h0, MASK_NONE);
    do_op(OP_DESELECT, 3'h0, 14'h0000, 32'h0, MASK_NONE);
    do_op(OP_NOP, 3'h0, 14'h0000, 32'h0, MASK_NONE);
    `CHK("no command", 0, cmd_cnt - c0)
    `CHK("select held", 2'b10, {cke, cs_n})
  endtask : t_refresh_power

  initial
  begin
    #100000;
    n_fail++;
    test_done();
  end

  initial
  begin
    n_fail = 0;
    checked = 0;
    reset_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    mute = 1'b0;
    slow = 1'b0;
    repeat (5) @(posedge sys_clk);
    t_idle();
    @(posedge sys_clk);
    #2;
    reset_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    t_row_ops();
    t_mode();
    t_read();
    t_write();
    t_refresh_power();
    t_idle();
    test_done();
  end
endmodule : ddrpi_command_pins_tb

// file: ddrpi_mem_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Behavioural memory device on the far side of the pins.
// ****************************************************************
module ddrpi_mem_model
  import ddrpi_pkg::*;
#(
  parameter logic [DATA_W-1:0] RD_WORD = 32'h5a3c_96e1
) (
  input  wire logic              link_clk,
  input  wire logic              mute,
  input  wire logic              slow,
  input  wire logic              mem_row_strobe_n,
  input  wire logic              mem_col_strobe_n,
  input  wire logic              mem_write_enable_n,
  input  wire logic [BANK_W-1:0] mem_bank_select,
  input  wire logic [ADDR_W-1:0] mem_address_out,
  input  wire logic [LANES-1:0]  mem_byte_mask_n,
  input  wire logic [DATA_W-1:0] mem_data_bus_out,
  input  wire logic              mem_data_bus_oe_n,
  input  wire logic [LANES-1:0]  mem_data_strobe_pair_out,
  input  wire logic [LANES-1:0]  mem_data_strobe_pair_out_n,
  output logic      [DATA_W-1:0] mem_data_bus_in,
  output logic      [LANES-1:0]  read_strobe_gate,
  output ddrpi_cmd_s             last_cmd,
  output ddrpi_cmd_s             prev_cmd,
  output int                     cmd_cnt,
  output logic      [DATA_W-1:0] wr_data,
  output logic      [LANES-1:0]  wr_mask,
  output logic      [7:0]        wr_strobe
);
  ddrpi_cmd_s cur;
  int         rd_wait;
  logic       first_beat;

  initial
  begin
    mem_data_bus_in = 32'h0;
    read_strobe_gate = 4'h0;
    last_cmd = '1;
    prev_cmd = '1;
    cmd_cnt = 0;
    rd_wait = 0;
    first_beat = 1'b1;
  end

  // The memory samples its pins on the falling edge of link_clk, the rising edge of the complement clock phase.
  always @(negedge link_clk)
  begin
    cur = {mem_row_strobe_n, mem_col_strobe_n, mem_write_enable_n, mem_bank_select,
           mem_address_out};
    if (!(cur.ras_n && cur.cas_n && cur.we_n))
    begin
      prev_cmd <= last_cmd;
      last_cmd <= cur;
      cmd_cnt  <= cmd_cnt + 1;
    end
    rd_wait <= (rd_wait > 0) ? rd_wait - 1 : 0;
    if ({cur.ras_n, cur.cas_n, cur.we_n} == 3'b101 && !mute)
      rd_wait <= slow ? 8 : 4;
    // Read data is held around one gate cycle; a released bus toggles.
    mem_data_bus_in  <= (rd_wait inside {[1:3]}) ? RD_WORD : ~mem_data_bus_in;
    read_strobe_gate <= (rd_wait == 2) ? 4'hf : 4'h0;
    if (!mem_data_bus_oe_n && first_beat)
    begin
      wr_data   <= mem_data_bus_out;
      wr_mask   <= mem_byte_mask_n;
      wr_strobe <= {mem_data_strobe_pair_out, mem_data_strobe_pair_out_n};
    end
    first_beat <= mem_data_bus_oe_n;
  end
endmodule : ddrpi_mem_model

// file: ddrpi_pkg.sv
// ****************************************************************
// Shared constants and types for the memory command pin block.
// ****************************************************************
package ddrpi_pkg;

  localparam int DATA_W        = 32;
  localparam int ADDR_W        = 14;
  localparam int BANK_W        = 3;
  localparam int LANES         = 4;
  localparam int ODT_W         = 2;
  localparam int A10_BIT       = 10;
  localparam int MODE_ADDR_MSB = 12;

  localparam logic [2:0]        WRITE_LAST_BEAT = 3'h3;
  localparam logic [4:0]        READ_TIMEOUT    = 5'h10;
  localparam logic [ODT_W-1:0]  ODT_OFF         = 2'h0;
  localparam logic [LANES-1:0]  MASK_ALL        = 4'h0;
  localparam logic [LANES-1:0]  MASK_NONE       = 4'hf;
  localparam logic [ADDR_W-1:0] ADDR_ALL_BANKS  = 14'h0400;

  typedef enum logic [3:0] {
    OP_NOP,
    OP_ACTIVATE,
    OP_PRECHARGE_ALL,
    OP_PRECHARGE_ONE,
    OP_MODE_SET,
    OP_EXT_MODE_SET,
    OP_READ,
    OP_READ_AP,
    OP_WRITE,
    OP_WRITE_AP,
    OP_AUTOREFRESH,
    OP_SELF_REFRESH_ENTRY,
    OP_SELF_REFRESH_EXIT,
    OP_POWER_DOWN_ENTRY,
    OP_POWER_DOWN_EXIT,
    OP_DESELECT
  } ddrpi_op_e;

  typedef struct packed {
    ddrpi_op_e         op;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [LANES-1:0]  byte_mask_n;
  } ddrpi_req_s;

  typedef struct packed {
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
  } ddrpi_cmd_s;

endpackage : ddrpi_pkg

// file: ddrpi_sync.sv
`timescale 1ns/1ps
// ****************************************************************
// Two flip-flop synchroniser.
// ****************************************************************
module ddrpi_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta <= '0;
      q    <= '0;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule : ddrpi_sync
